// ---- hdl/meter_cfg_pkg.sv ----
// Purpose: shared constants and carrier types of the meter configuration register bank
// Assumes: 8-bit processor bus, special-function space below 0x0100, extended space 0x2xxx
// Notes: every offset, field position, reset and wake value lives here
package meter_cfg_pkg;

    // special-function space
    localparam logic [15:0] ADR_P0_DATA = 16'h0080;
    localparam logic [15:0] ADR_P1_DATA = 16'h0090;
    localparam logic [15:0] ADR_P1_DIR = 16'h0091;
    localparam logic [15:0] ADR_ERASE = 16'h0094;
    localparam logic [15:0] ADR_EE_DATA = 16'h009e;
    localparam logic [15:0] ADR_EE_CTRL = 16'h009f;
    localparam logic [15:0] ADR_P2_DATA = 16'h00a0;
    localparam logic [15:0] ADR_P2_DIR = 16'h00a1;
    localparam logic [15:0] ADR_P0_DIR = 16'h00a2;
    localparam logic [15:0] ADR_FL_CTRL = 16'h00b2;
    localparam logic [15:0] ADR_PG_ADDR = 16'h00b7;
    localparam logic [15:0] ADR_INT_FLAGS = 16'h00e8;
    localparam logic [15:0] ADR_INT_BITS = 16'h00f8;
    // extended configuration space
    localparam logic [15:0] ADR_CE_CTRL = 16'h2000;
    localparam logic [15:0] ADR_CHOP_CTRL = 16'h2002;
    localparam logic [15:0] ADR_COMP = 16'h2003;
    localparam logic [15:0] ADR_CKOUT = 16'h2004;
    localparam logic [15:0] ADR_ADC = 16'h2005;
    localparam logic [15:0] ADR_BATT = 16'h2020;
    localparam logic [15:0] ADR_CE_LOC = 16'h20a8;

    // field positions
    localparam int CE_EN_BIT = 4;
    localparam int CHOP_LSB = 4;
    localparam int CK_LSB = 4;
    localparam int ADC_EN_BIT = 3;
    localparam int BME_BIT = 6;
    localparam int COMP_BIT = 0;
    localparam int CE_PAGE_BITS = 10; // start address = location * 1024

    // implemented bits; everything outside a mask has no storage
    localparam logic [7:0] MASK_P0 = 8'hff;
    localparam logic [7:0] MASK_P1 = 8'hff;
    localparam logic [7:0] MASK_P2 = 8'h3f;
    localparam logic [7:0] MASK_FL_CTRL = 8'hc3;
    localparam logic [7:0] MASK_PG_ADDR = 8'hfe;
    localparam logic [7:0] MASK_INT_BITS = 8'h7f;

    // values after reset and after wake
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_WAKE = 8'h00;
    localparam logic ADC_RST = 1'b0;
    localparam logic ADC_WAKE = 1'b0;
    localparam logic CE_RST = 1'b0;
    localparam logic CE_WAKE = 1'b0;
    localparam logic BME_RST = 1'b0;
    localparam logic [4:0] LOC_RST = 5'h1f;
    localparam logic [4:0] LOC_WAKE = 5'h1f;
    localparam logic [1:0] CHOP_RST = 2'h0;
    localparam logic [1:0] CHOP_WAKE = 2'h0;
    localparam logic [1:0] CK_RST = 2'h0;
    localparam logic [1:0] CK_WAKE = 2'h0;
    localparam logic CHOP_STATE_RST = 1'b0;

    typedef enum logic [1:0] {
        CHOP_TOGGLE_A = 2'h0,
        CHOP_POSITIVE = 2'h1,
        CHOP_REVERSED = 2'h2,
        CHOP_TOGGLE_B = 2'h3
    } chopSel_t;

    typedef enum logic [1:0] {
        CK_SEGMENT = 2'h0,
        CK_FILTER = 2'h1,
        CK_TEST_A = 2'h2,
        CK_TEST_B = 2'h3
    } ckSel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } busReq_t;

    typedef struct packed {
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } portPins_t;

    typedef struct packed {
        logic adcEnable;
        logic refEnable;
        logic batteryLoad;
        logic batteryToConverter;
        logic ceEnable;
        logic [14:0] ceStartAddr;
    } analogCtl_t;

endpackage

// ---- hdl/pin_sync3.sv ----
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: the output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 8
) (
    input wire logic clk, // processor clock
    input wire logic srst, // synchronous reset, high
    input wire logic [W-1:0] pinIn, // raw pin levels
    output logic [W-1:0] pinSync // filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } syncSt_t;

    syncSt_t q;
    syncSt_t d;

    // stage one feeds stage two only; the agree test uses two and three
    always_comb begin
        d = q;
        d.s1 = pinIn;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.o[i] = q.s3[i];
            end
        end
        if (srst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign pinSync = q.o;
endmodule

// ---- hdl/ref_chop_ctrl.sv ----
// Purpose: reference chop state driven by the multiplexer sync edge
// Assumes: multiplexer sync and summation interval end come from on-chip logic on clk
// Notes: the end-of-interval level must be valid in the cycle of the sync rising edge
`timescale 1ns/1ps
module ref_chop_ctrl (
    input wire logic clk, // processor clock
    input wire logic srst, // synchronous reset, high
    input wire logic multiplexerSync, // multiplexer sync level
    input wire logic summationIntervalEnd, // high when this sync edge closes an interval
    input wire logic [1:0] chopSelect, // chop mode
    output logic chopState // 1 = positive, 0 = reversed
);
    typedef struct packed {
        logic syncPrev;
        logic chop;
    } chopSt_t;

    chopSt_t q;
    chopSt_t d;
    logic syncRise;

    assign syncRise = multiplexerSync & ~q.syncPrev;

    // chop moves only on a sync rising edge
    always_comb begin
        d = q;
        d.syncPrev = multiplexerSync;
        if (syncRise) begin
            case (meter_cfg_pkg::chopSel_t'(chopSelect))
                meter_cfg_pkg::CHOP_POSITIVE: d.chop = 1'b1; // RULE_10
                meter_cfg_pkg::CHOP_REVERSED: d.chop = 1'b0; // RULE_10
                default: d.chop = summationIntervalEnd ? q.chop : ~q.chop; // RULE_11
            endcase
        end
        if (srst) begin
            d.syncPrev = 1'b0;
            d.chop = meter_cfg_pkg::CHOP_STATE_RST;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign chopState = q.chop;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence toggleEdge;
        syncRise && (chopSelect == 2'h0 || chopSelect == 2'h3);
    endsequence

    AST_CHOP_FORCED: assert property (syncRise && chopSelect == 2'h1 |=> chopState) // RULE_10
        else $error("chop not forced positive");
    AST_CHOP_TOGGLE: assert property (toggleEdge and !summationIntervalEnd |=> // RULE_10
        chopState != $past(chopState))
        else $error("chop did not toggle");
    AST_CHOP_SKIP: assert property (toggleEdge and summationIntervalEnd |=> // RULE_11
        $stable(chopState))
        else $error("chop toggled at interval end");
endmodule

// ---- hdl/meter_cfg_regs.sv ----
// Purpose: configuration and status register bank of the metering processor
// Assumes: one clock, synchronous reset, wake pulse from the power manager on clk
// Notes: reads answer one cycle after the read strobe; writes land on the next edge
//
// Summary of operation
// RULE_01 - bits without storage always read as zero.
// RULE_02 - software writes reserved bits back unchanged, so they are kept as plain storage.
// RULE_03 - write-only registers read back as zero.
// RULE_04 - each setting has a reset and a wake value; read-only and retained bits skip them. Wake leaves flash, eeprom and interrupt bits as they are.
// RULE_05 - busy settings sit in the special-function space, the rest at 0x2xxx.
// RULE_06 - software copies the settings from flash into the bank after start-up.
// RULE_07 - the converter enable resets to zero and switches converter and reference bias.
// RULE_08 - battery measure applies the load at once and routes the battery on alternate cycles.
// RULE_09 - compute engine start address is 1024 times the location field, which resets to 31.
// RULE_10 - the chop state follows the chop select on each multiplexer sync rising edge.
// RULE_11 - in toggle modes the toggle is skipped at the edge ending a summation interval.
// RULE_12 - clock test select resets to 00 for the segment function; 01 gives the filter clock.
// RULE_13 - a read-only bit shows the live power-fail comparator on the first sense input.
// RULE_14 - each access completes in one bus cycle with no side effect beyond its own bits.
`timescale 1ns/1ps
module meter_cfg_regs (
    input wire logic clk, // processor clock, 25 MHz
    input wire logic srst, // synchronous reset, high
    input wire logic wake, // one-cycle wake pulse
    input wire meter_cfg_pkg::busReq_t bus, // processor access
    output logic [7:0] rdData, // read answer, valid the cycle after rd
    input wire meter_cfg_pkg::portPins_t pinIn, // port pin levels, asynchronous
    output meter_cfg_pkg::portPins_t pinOut, // port pin drive values
    output meter_cfg_pkg::portPins_t pinOe, // port pin enables, high drives
    input wire logic [7:0] interruptEvent, // event pulses setting interrupt flags
    output logic [7:0] interruptFlags, // sticky interrupt flags
    output logic [6:0] interruptInputBits, // interrupt input bits
    output logic [7:0] flashEraseCode, // last erase command
    output logic flashEraseStrobe, // pulse when erase is written
    output logic [7:0] flashControl, // flash control bits
    output logic [7:0] flashPageAddress, // flash page address
    output logic [7:0] serialEepromData, // serial eeprom data
    output logic [7:0] serialEepromControl, // serial eeprom control
    output meter_cfg_pkg::analogCtl_t analogCtl, // analogue enables
    input wire logic alternateMultiplexerCycle, // alternate mux cycle in progress
    input wire logic multiplexerSync, // multiplexer sync
    input wire logic summationInterval, // sync edge ends a summation interval
    output logic chopState, // reference chop state
    input wire logic comparatorIn, // power-fail comparator, first sense input
    input wire logic segmentDriverNineteen, // segment driver level
    input wire logic filterClock, // filter clock level
    output logic clockTestPin // clock test pin drive
);
    typedef struct packed {
        logic [7:0] p0Data;
        logic [7:0] p1Data;
        logic [7:0] p2Data;
        logic [7:0] p0Dir;
        logic [7:0] p1Dir;
        logic [7:0] p2Dir;
        logic [7:0] eraseCode;
        logic eraseStrobe;
        logic [7:0] serial_eeprom_data;
        logic [7:0] serial_eeprom_control;
        logic [7:0] flashCtl;
        logic [7:0] pageAddr;
        logic [7:0] intFlags;
        logic [6:0] interrupt_input_bits;
        logic ceEnable;
        logic adcEnable;
        logic battery_measure_enable;
        logic battMux;
        logic [4:0] loc;
        logic [14:0] ceStart;
        logic [1:0] chopSel;
        logic [1:0] ckSel;
        logic ckPin;
        logic [7:0] rdata;
    } st_t;

    st_t q;
    st_t d;
    logic [24:0] syncOut;
    meter_cfg_pkg::portPins_t pinLvl;
    logic compLive;
    logic [7:0] rv;
    logic [7:0] wd;
    logic wr;

    // pins and comparator are asynchronous; one filtered bank for all of them
    pin_sync3 #(
        .W(25)
    ) pin_sync3_inst (
        .clk(clk),
        .srst(srst),
        .pinIn({comparatorIn, pinIn}),
        .pinSync(syncOut)
    );

    assign pinLvl = syncOut[23:0];
    assign compLive = syncOut[24];

    ref_chop_ctrl ref_chop_ctrl_inst (
        .clk(clk),
        .srst(srst),
        .multiplexerSync(multiplexerSync),
        .summationIntervalEnd(summationInterval),
        .chopSelect(q.chopSel),
        .chopState(chopState)
    );

    assign wr = bus.wr;
    assign wd = bus.wdata;

    // read mux; anything unmapped or without storage answers zero
    always_comb begin
        rv = 8'h00;
        if (bus.addr == meter_cfg_pkg::ADR_P0_DATA) begin
            rv = pinLvl.p0 & meter_cfg_pkg::MASK_P0;
        end else if (bus.addr == meter_cfg_pkg::ADR_P1_DATA) begin
            rv = pinLvl.p1 & meter_cfg_pkg::MASK_P1;
        end else if (bus.addr == meter_cfg_pkg::ADR_P2_DATA) begin
            rv = pinLvl.p2 & meter_cfg_pkg::MASK_P2; // RULE_01
        end else if (bus.addr == meter_cfg_pkg::ADR_P0_DIR) begin
            rv = q.p0Dir;
        end else if (bus.addr == meter_cfg_pkg::ADR_P1_DIR) begin
            rv = q.p1Dir;
        end else if (bus.addr == meter_cfg_pkg::ADR_P2_DIR) begin
            rv = q.p2Dir;
        end else if (bus.addr == meter_cfg_pkg::ADR_ERASE) begin
            rv = 8'h00; // RULE_03
        end else if (bus.addr == meter_cfg_pkg::ADR_EE_DATA) begin
            rv = q.serial_eeprom_data;
        end else if (bus.addr == meter_cfg_pkg::ADR_EE_CTRL) begin
            rv = q.serial_eeprom_control;
        end else if (bus.addr == meter_cfg_pkg::ADR_FL_CTRL) begin
            rv = q.flashCtl;
        end else if (bus.addr == meter_cfg_pkg::ADR_PG_ADDR) begin
            rv = q.pageAddr;
        end else if (bus.addr == meter_cfg_pkg::ADR_INT_FLAGS) begin
            rv = q.intFlags;
        end else if (bus.addr == meter_cfg_pkg::ADR_INT_BITS) begin
            rv = {1'b0, q.interrupt_input_bits};
        end else if (bus.addr == meter_cfg_pkg::ADR_CE_CTRL) begin
            rv[meter_cfg_pkg::CE_EN_BIT] = q.ceEnable;
        end else if (bus.addr == meter_cfg_pkg::ADR_CHOP_CTRL) begin
            rv[meter_cfg_pkg::CHOP_LSB +: 2] = q.chopSel;
        end else if (bus.addr == meter_cfg_pkg::ADR_COMP) begin
            rv[meter_cfg_pkg::COMP_BIT] = compLive; // RULE_13
        end else if (bus.addr == meter_cfg_pkg::ADR_CKOUT) begin
            rv[meter_cfg_pkg::CK_LSB +: 2] = q.ckSel;
        end else if (bus.addr == meter_cfg_pkg::ADR_ADC) begin
            rv[meter_cfg_pkg::ADC_EN_BIT] = q.adcEnable;
        end else if (bus.addr == meter_cfg_pkg::ADR_BATT) begin
            rv[meter_cfg_pkg::BME_BIT] = q.battery_measure_enable;
        end else if (bus.addr == meter_cfg_pkg::ADR_CE_LOC) begin
            rv[4:0] = q.loc;
        end
    end

    // next state: writes, hardware events, then wake and reset override
    always_comb begin
        d = q;
        d.eraseStrobe = 1'b0;
        d.intFlags = q.intFlags | interruptEvent;
        if (bus.rd) begin
            d.rdata = rv; // RULE_14
        end
        // special-function space first, extended window below it
        if (wr) begin
            if (bus.addr == meter_cfg_pkg::ADR_P0_DATA) begin
                d.p0Data = wd & meter_cfg_pkg::MASK_P0; // RULE_02
            end else if (bus.addr == meter_cfg_pkg::ADR_P1_DATA) begin
                d.p1Data = wd & meter_cfg_pkg::MASK_P1;
            end else if (bus.addr == meter_cfg_pkg::ADR_P2_DATA) begin
                d.p2Data = wd & meter_cfg_pkg::MASK_P2; // RULE_01
            end else if (bus.addr == meter_cfg_pkg::ADR_P0_DIR) begin
                d.p0Dir = wd & meter_cfg_pkg::MASK_P0; // RULE_02
            end else if (bus.addr == meter_cfg_pkg::ADR_P1_DIR) begin
                d.p1Dir = wd & meter_cfg_pkg::MASK_P1;
            end else if (bus.addr == meter_cfg_pkg::ADR_P2_DIR) begin
                d.p2Dir = wd & meter_cfg_pkg::MASK_P2;
            end else if (bus.addr == meter_cfg_pkg::ADR_ERASE) begin
                d.eraseCode = wd;
                d.eraseStrobe = 1'b1;
            end else if (bus.addr == meter_cfg_pkg::ADR_EE_DATA) begin
                d.serial_eeprom_data = wd;
            end else if (bus.addr == meter_cfg_pkg::ADR_EE_CTRL) begin
                d.serial_eeprom_control = wd;
            end else if (bus.addr == meter_cfg_pkg::ADR_FL_CTRL) begin
                d.flashCtl = wd & meter_cfg_pkg::MASK_FL_CTRL; // RULE_01
            end else if (bus.addr == meter_cfg_pkg::ADR_PG_ADDR) begin
                d.pageAddr = wd & meter_cfg_pkg::MASK_PG_ADDR;
            end else if (bus.addr == meter_cfg_pkg::ADR_INT_FLAGS) begin
                d.intFlags = wd | interruptEvent; // an event wins over a clear
            end else if (bus.addr == meter_cfg_pkg::ADR_INT_BITS) begin
                d.interrupt_input_bits = wd[6:0] & meter_cfg_pkg::MASK_INT_BITS[6:0];
            end else if (bus.addr == meter_cfg_pkg::ADR_CE_CTRL) begin // RULE_05
                d.ceEnable = wd[meter_cfg_pkg::CE_EN_BIT];
            end else if (bus.addr == meter_cfg_pkg::ADR_CHOP_CTRL) begin
                d.chopSel = wd[meter_cfg_pkg::CHOP_LSB +: 2];
            end else if (bus.addr == meter_cfg_pkg::ADR_CKOUT) begin
                d.ckSel = wd[meter_cfg_pkg::CK_LSB +: 2];
            end else if (bus.addr == meter_cfg_pkg::ADR_ADC) begin
                d.adcEnable = wd[meter_cfg_pkg::ADC_EN_BIT]; // RULE_07
            end else if (bus.addr == meter_cfg_pkg::ADR_BATT) begin
                d.battery_measure_enable = wd[meter_cfg_pkg::BME_BIT]; // RULE_08
            end else if (bus.addr == meter_cfg_pkg::ADR_CE_LOC) begin
                d.loc = wd[4:0];
            end
        end
        // wake restores port and 0x2xxx settings but leaves battery measure, flash, eeprom and interrupt bits retained
        if (wake || srst) begin
            d.p0Data = meter_cfg_pkg::BYTE_WAKE; // RULE_04
            d.p1Data = meter_cfg_pkg::BYTE_WAKE;
            d.p2Data = meter_cfg_pkg::BYTE_WAKE;
            d.p0Dir = meter_cfg_pkg::BYTE_WAKE;
            d.p1Dir = meter_cfg_pkg::BYTE_WAKE;
            d.p2Dir = meter_cfg_pkg::BYTE_WAKE;
            d.ceEnable = meter_cfg_pkg::CE_WAKE;
            d.adcEnable = meter_cfg_pkg::ADC_WAKE;
            d.loc = meter_cfg_pkg::LOC_WAKE;
            d.chopSel = meter_cfg_pkg::CHOP_WAKE;
            d.ckSel = meter_cfg_pkg::CK_WAKE;
        end
        if (srst) begin
            d.adcEnable = meter_cfg_pkg::ADC_RST; // RULE_07
            d.ceEnable = meter_cfg_pkg::CE_RST;
            d.battery_measure_enable = meter_cfg_pkg::BME_RST; // RULE_04
            d.loc = meter_cfg_pkg::LOC_RST; // RULE_09
            d.chopSel = meter_cfg_pkg::CHOP_RST;
            d.ckSel = meter_cfg_pkg::CK_RST; // RULE_12
            d.eraseCode = meter_cfg_pkg::BYTE_RST;
            d.eraseStrobe = 1'b0;
            d.serial_eeprom_data = meter_cfg_pkg::BYTE_RST;
            d.serial_eeprom_control = meter_cfg_pkg::BYTE_RST;
            d.flashCtl = meter_cfg_pkg::BYTE_RST;
            d.pageAddr = meter_cfg_pkg::BYTE_RST;
            d.intFlags = meter_cfg_pkg::BYTE_RST;
            d.interrupt_input_bits = 7'h00;
            d.rdata = meter_cfg_pkg::BYTE_RST;
        end
        // start address and battery routing are registered from the settled next values; the clock test pin from the current select
        d.ceStart = {d.loc, {meter_cfg_pkg::CE_PAGE_BITS{1'b0}}}; // RULE_09
        d.battMux = d.battery_measure_enable & alternateMultiplexerCycle & ~srst; // RULE_08
        case (meter_cfg_pkg::ckSel_t'(q.ckSel))
            meter_cfg_pkg::CK_SEGMENT: d.ckPin = segmentDriverNineteen; // RULE_12
            meter_cfg_pkg::CK_FILTER: d.ckPin = filterClock; // RULE_12
            default: d.ckPin = 1'b0; // test codes are never used in the field
        endcase
        if (srst) begin
            d.ckPin = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // every output straight from a state flop
    assign rdData = q.rdata;
    assign pinOut = {q.p2Data, q.p1Data, q.p0Data};
    assign pinOe = {q.p2Dir, q.p1Dir, q.p0Dir};
    assign interruptFlags = q.intFlags;
    assign interruptInputBits = q.interrupt_input_bits;
    assign flashEraseCode = q.eraseCode;
    assign flashEraseStrobe = q.eraseStrobe;
    assign flashControl = q.flashCtl;
    assign flashPageAddress = q.pageAddr;
    assign serialEepromData = q.serial_eeprom_data;
    assign serialEepromControl = q.serial_eeprom_control;
    assign analogCtl.adcEnable = q.adcEnable; // RULE_07
    assign analogCtl.refEnable = q.adcEnable; // bias removed with the same bit
    assign analogCtl.batteryLoad = q.battery_measure_enable; // RULE_08
    assign analogCtl.batteryToConverter = q.battMux;
    assign analogCtl.ceEnable = q.ceEnable;
    assign analogCtl.ceStartAddr = q.ceStart;
    assign clockTestPin = q.ckPin;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence readAt(logic [15:0] a);
        bus.rd && bus.addr == a;
    endsequence

    sequence writeAt(logic [15:0] a);
        bus.wr && bus.addr == a && !wake;
    endsequence

    AST_UNUSED_ZERO: assert property (readAt(meter_cfg_pkg::ADR_FL_CTRL) |=> // RULE_01
        rdData[5:2] == 4'h0)
        else $error("unused flash control bits read nonzero");
    AST_WRITE_ONLY: assert property (readAt(meter_cfg_pkg::ADR_ERASE) |=> // RULE_03
        rdData == 8'h00)
        else $error("erase command read nonzero");
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (1'b0) srst |=> // RULE_04
        !analogCtl.adcEnable && analogCtl.ceStartAddr == 15'h7c00 && !clockTestPin)
        else $error("reset values wrong");
    AST_WAKE_KEEPS_BME: assert property (wake && !bus.wr |=> // RULE_04
        analogCtl.batteryLoad == $past(analogCtl.batteryLoad))
        else $error("wake disturbed battery measure");
    AST_ADC_FOLLOWS: assert property (writeAt(meter_cfg_pkg::ADR_ADC) |=> // RULE_07
        analogCtl.adcEnable == $past(bus.wdata[meter_cfg_pkg::ADC_EN_BIT]) &&
        analogCtl.refEnable == analogCtl.adcEnable)
        else $error("converter enable did not follow write");
    AST_BATT_LOAD: assert property (writeAt(meter_cfg_pkg::ADR_BATT) ##1 // RULE_08
        (analogCtl.batteryLoad && alternateMultiplexerCycle) |=>
        analogCtl.batteryToConverter)
        else $error("battery not routed on alternate cycle");
    // a write or wake in the read cycle moves the location after the old value is read
    AST_CE_ADDR: assert property (readAt(meter_cfg_pkg::ADR_CE_LOC) // RULE_09
        ##0 !(bus.wr || wake) |=>
        {rdData[4:0], 10'h000} == analogCtl.ceStartAddr)
        else $error("start address mismatch");
    AST_CLOCK_TEST_PIN_SEG: assert property (q.ckSel == 2'h0 ##1 q.ckSel == 2'h0 |-> // RULE_12
        clockTestPin == $past(segmentDriverNineteen))
        else $error("clock test pin not on segment");
    AST_COMP_LIVE: assert property (readAt(meter_cfg_pkg::ADR_COMP) |=> // RULE_13
        rdData == {7'h00, $past(compLive)})
        else $error("comparator status wrong");
    AST_READ_HOLD: assert property (!bus.rd |=> $stable(rdData)) // RULE_14
        else $error("read data changed without a read");
endmodule

// ---- verification/meter_cfg_regs_tb.sv ----
// Purpose: self-checking bench of the configuration register bank
// Assumes: reads answer one cycle after the strobe; inputs move on the falling edge
// Notes: pin inputs are held quiet; events, mux cycle and clock sources are driven
`timescale 1ns/1ps
module meter_cfg_regs_tb;
    logic clk, srst, wake, mSync, sumEnd, cmp, fClk, chop, ckPin;
    logic [7:0] rdData;
    meter_cfg_pkg::busReq_t bus;
    meter_cfg_pkg::analogCtl_t ana;
    logic alt, seg, fStb;
    logic [7:0] ev, iFlg, fCode, fCtl, pgA, eeD, eeC;
    logic [6:0] iBits;
    meter_cfg_pkg::portPins_t pOut, pOe;
    int stbCount = 0;
    int fail_count = 0;
    int samples_checked = 0;
    meter_cfg_regs meter_cfg_regs_inst (.clk(clk), .srst(srst), .wake(wake), .bus(bus),
        .rdData(rdData), .pinIn(24'h0), .pinOut(pOut), .pinOe(pOe), .interruptEvent(ev),
        .interruptFlags(iFlg), .interruptInputBits(iBits), .flashEraseCode(fCode),
        .flashEraseStrobe(fStb), .flashControl(fCtl), .flashPageAddress(pgA),
        .serialEepromData(eeD), .serialEepromControl(eeC), .analogCtl(ana),
        .alternateMultiplexerCycle(alt), .multiplexerSync(mSync),
        .summationInterval(sumEnd), .chopState(chop), .comparatorIn(cmp),
        .segmentDriverNineteen(seg), .filterClock(fClk), .clockTestPin(ckPin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one strobe cycle, then a spare cycle so the effect has landed
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        bus.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        bus = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk);
        bus.rd = 1'b0;
        chk({8'h00, rdData}, {8'h00, exp});
    endtask
    // one sync rising edge, with or without the end of a summation interval
    task automatic sync(input logic s, input logic exp);
        @(negedge clk);
        mSync = 1'b1;
        sumEnd = s;
        @(negedge clk);
        mSync = 1'b0;
        sumEnd = 1'b0;
        @(negedge clk);
        chk({15'h0, chop}, {15'h0, exp});
    endtask
    task automatic complete_run;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a one-cycle erase strobe is seen by exactly one falling edge
    always @(negedge clk) if (fStb === 1'b1) stbCount++;
    // 25 MHz processor clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // the run needs some 150 cycles; 2000 leaves ample margin
    initial begin
        #80000;
        fail_count++;
        complete_run();
    end
    // directed sequence of register accesses
    initial begin
        srst = 1'b1;
        wake = 1'b0;
        mSync = 1'b0;
        sumEnd = 1'b0;
        cmp = 1'b0;
        fClk = 1'b0;
        seg = 1'b1;
        alt = 1'b0;
        ev = 8'h00;
        bus = '0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        rd(16'h20a8, 8'h1f);
        chk({1'b0, ana.ceStartAddr}, 16'h7c00);
        wr(16'h20a8, 8'hff);
        rd(16'h20a8, 8'h1f);
        wr(16'h20a8, 8'h05);
        chk({1'b0, ana.ceStartAddr}, 16'h1400);
        // location first, only then the engine is enabled
        wr(16'h2000, 8'h10);
        rd(16'h2000, 8'h10);
        chk({15'h0, ana.ceEnable}, 16'h0001);
        wr(16'h2005, 8'hff);
        rd(16'h2005, 8'h08);
        chk({14'h0, ana.adcEnable, ana.refEnable}, 16'h0003);
        wr(16'h0094, 8'h5a);
        rd(16'h0094, 8'h00);
        chk({fCode, stbCount[7:0]}, 16'h5a01);
        wr(16'h00b2, 8'hff);
        rd(16'h00b2, 8'hc3);
        wr(16'h00b7, 8'hff);
        rd(16'h00b7, 8'hfe);
        chk({fCtl, pgA}, 16'hc3fe);
        wr(16'h00f8, 8'hff);
        rd(16'h00f8, 8'h7f);
        chk({9'h000, iBits}, 16'h007f);
        wr(16'h009e, 8'h3c);
        wr(16'h009f, 8'hc5);
        chk({eeD, eeC}, 16'h3cc5);
        wr(16'h00a2, 8'hf6);
        wr(16'h0080, 8'ha5);
        wr(16'h00a0, 8'hff);
        rd(16'h0080, 8'h00);
        chk({pOe.p0, pOut.p0}, 16'hf6a5);
        chk({8'h00, pOut.p2}, 16'h003f);
        ev = 8'h11;
        @(negedge clk);
        ev = 8'h00;
        rd(16'h00e8, 8'h11);
        wr(16'h00e8, 8'h01);
        chk({8'h00, iFlg}, 16'h0001);
        rd(16'h2001, 8'h00);
        rd(16'h2004, 8'h00);
        chk({15'h0, ckPin}, 16'h0001);
        wr(16'h2004, 8'h10);
        chk({15'h0, ckPin}, 16'h0000);
        fClk = 1'b1;
        repeat (2) @(negedge clk);
        chk({15'h0, ckPin}, 16'h0001);
        alt = 1'b1;
        wr(16'h2020, 8'hff);
        rd(16'h2020, 8'h40);
        chk({14'h0, ana.batteryLoad, ana.batteryToConverter}, 16'h0003);
        alt = 1'b0;
        wr(16'h2002, 8'h30);
        chk({15'h0, ana.batteryToConverter}, 16'h0000);
        // wake resets the port and 0x2xxx settings to their wake values but leaves battery measure alone
        @(negedge clk);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        rd(16'h2020, 8'h40);
        rd(16'h2005, 8'h00);
        rd(16'h20a8, 8'h1f);
        rd(16'h2000, 8'h00);
        rd(16'h2004, 8'h00);
        rd(16'h2002, 8'h00);
        chk({pOe.p0, pOut.p0}, 16'h0000);
        wr(16'h2002, 8'h10);
        sync(1'b0, 1'b1);
        wr(16'h2002, 8'h20);
        sync(1'b0, 1'b0);
        wr(16'h2002, 8'h30);
        sync(1'b0, 1'b1);
        sync(1'b1, 1'b1);
        wr(16'h2002, 8'h00);
        sync(1'b0, 1'b0);
        sync(1'b1, 1'b0);
        cmp = 1'b1;
        repeat (6) @(negedge clk);
        rd(16'h2003, 8'h01);
        cmp = 1'b0;
        repeat (6) @(negedge clk);
        rd(16'h2003, 8'h00);
        complete_run();
    end
endmodule
